//--- field_quantizer.sv
// 8-bit quantiser from a signed field sample to a ratiometric output code
// assumes the field sample is on the same clock as this module
`timescale 1ns/1ns
`default_nettype none
`include "hall_defines.svh"

module field_quantizer #(
	parameter int FIELD_W = `HALL_FIELD_W,
	parameter int FRAC_W  = `HALL_FIELD_FRAC_W
) (
	input  wire logic                      clock_in,
	input  wire logic                      rst_b_in,
	input  wire logic signed [FIELD_W-1:0] field_in,
	output logic         [`HALL_CODE_W-1:0] code_out
);

	if (FIELD_W < `HALL_CODE_W || FRAC_W >= FIELD_W) begin : g_bad_width
		$error("field_quantizer: field width too small for the fraction width");
	end

	wire logic signed [FIELD_W:0] field_ext;
	wire logic signed [FIELD_W:0] pos_steps;
	wire logic        [FIELD_W:0] neg_mag;
	wire logic        [FIELD_W:0] neg_steps;
	wire logic                    is_pos;
	wire logic                    pos_sat;
	wire logic                    neg_sat;
	wire logic [`HALL_CODE_W-1:0] code_d;

	assign field_ext = {field_in[FIELD_W-1], field_in};
	assign is_pos    = ~field_in[FIELD_W-1] & (|field_in);
	// null boundary
	// zero field rounds down to 0x7f, anything above it reaches 0x80
	assign pos_steps = (field_ext - (FIELD_W+1)'(1)) >>> FRAC_W;
	assign neg_mag   = -field_ext;
	assign neg_steps = neg_mag >> FRAC_W;
	assign pos_sat   = |pos_steps[FIELD_W:`HALL_HALF_STEPS_BIT];
	assign neg_sat   = |neg_steps[FIELD_W:`HALL_HALF_STEPS_BIT];
	// symmetric about null
	// south raises and north lowers by the same step count
	assign code_d = is_pos ? (pos_sat ? `HALL_CODE_MAX
	                                  : `HALL_CODE_NULL_HI + pos_steps[`HALL_CODE_W-1:0])
	                       : (neg_sat ? `HALL_CODE_MIN
	                                  : `HALL_CODE_NULL_LO - neg_steps[`HALL_CODE_W-1:0]);

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			code_out <= `HALL_CODE_RESET;
		end else begin
			code_out <= code_d;
		end
	end

endmodule

`default_nettype wire

//--- hall_defines.svh
// timing, code and width constants for the hall sample and mode control logic
// assumes a 10 MHz system clock and an internal sequencing tick of about 10 us
`ifndef HALL_DEFINES_SVH
`define HALL_DEFINES_SVH

// system clock and internal oscillator periods, in ns
`define HALL_CLK_PERIOD_NS      100
`define HALL_OSC_PERIOD_NS      10000
`define HALL_OSC_DIV            (`HALL_OSC_PERIOD_NS / `HALL_CLK_PERIOD_NS)

// least high time for a start pulse, in ns, and in clock cycles rounded up
`define HALL_PULSE_MIN_NS       20000
`define HALL_PULSE_MIN_CYC ((`HALL_PULSE_MIN_NS + `HALL_CLK_PERIOD_NS - 1) / `HALL_CLK_PERIOD_NS)

// sequence phases, in internal oscillator ticks
`define HALL_DELAY_TICKS        1
`define HALL_AWAKE_TICKS        12
`define HALL_UPDATE_TICKS       1
`define HALL_PULSED_TICKS       14
`define HALL_TURBO_TICKS        16
`define HALL_GAP_TICKS          (`HALL_TURBO_TICKS - `HALL_PULSED_TICKS)

// low-power sample rate, in Hz, and its period in ticks rounded down
`define HALL_MICRO_RATE_HZ      24
`define HALL_NS_PER_S           1000000000
`define HALL_MICRO_TICKS        ((`HALL_NS_PER_S / `HALL_MICRO_RATE_HZ) / `HALL_OSC_PERIOD_NS)

// output codes: step is supply/256, null sits between 0x7f and 0x80
`define HALL_CODE_MIN           8'h00
`define HALL_CODE_NULL_LO       8'h7F
`define HALL_CODE_NULL_HI       8'h80
`define HALL_CODE_MAX           8'hFF
`define HALL_CODE_RESET         8'h80
`define HALL_CODE_W             8
`define HALL_HALF_STEPS_BIT     7

// field sample format: signed, fraction bits below one code step
`define HALL_FIELD_W            16
`define HALL_FIELD_FRAC_W       8

`endif

//--- hall_pkg.sv
// types shared by the hall sample and mode control logic
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package hall_pkg;

	typedef enum logic [1:0] {
		MODE_MICRO  = 2'b00,
		MODE_TURBO  = 2'b01,
		MODE_PULSED = 2'b11
	} conv_mode_e;

	// gray codes along sleep, delay, awake, update, turbo gap
	typedef enum logic [2:0] {
		ST_SLEEP  = 3'b000,
		ST_DELAY  = 3'b001,
		ST_AWAKE  = 3'b011,
		ST_UPDATE = 3'b010,
		ST_GAP    = 3'b110
	} seq_state_e;

	typedef struct packed {
		logic       busy;
		logic       awake;
		logic       update;
		conv_mode_e mode;
	} status_s;

endpackage

`default_nettype wire

//--- hall_sample_mode_control.sv
// sampling and mode control for a linear hall sensor readout
// assumes the mode control pin and its driven flag come straight from the pad,
// and the field sample comes from front-end logic on the same clock
//
// Functional notes
// - pin held low gives 24 Hz sampling
// - undriven pin reads low, low-power default
// - pin held high converts every 16 ticks
// - each pin pulse starts one conversion
// - high pulse of at least 20 us starts sample
// - pulsed conversion lasts 14 ticks
// - one tick trigger delay in sleep
// - twelve awake ticks for acquisition
// - final tick loads output, then sleep
// - 8-bit converter and 8-bit output
// - code step is supply over 256
// - zero field between 0x7f and 0x80
// - south raises, north lowers, symmetric
`timescale 1ns/1ns
`default_nettype none
`include "hall_defines.svh"

module hall_sample_mode_control #(
	parameter int FIELD_W     = `HALL_FIELD_W,
	parameter int FRAC_W      = `HALL_FIELD_FRAC_W,
	parameter int OSC_DIV     = `HALL_OSC_DIV,
	parameter int MICRO_TICKS = `HALL_MICRO_TICKS
) (
	input  wire logic                      clock_in,
	input  wire logic                      rst_b_in,
	input  wire logic                      mode_control_pin_in,
	input  wire logic                      mode_pin_driven_in,
	input  wire logic signed [FIELD_W-1:0] field_sample_in,
	output logic        [`HALL_CODE_W-1:0] output_code_out,
	output hall_pkg::status_s              status_out
);

	localparam int DIV_W   = $clog2(OSC_DIV + 1);
	localparam int MICRO_W = $clog2(MICRO_TICKS + 1);
	localparam int PULSE_W = $clog2(`HALL_PULSE_MIN_CYC + 1);
	localparam int SEQ_W   = 4;

	localparam logic [DIV_W-1:0]   DIV_LAST   = DIV_W'(OSC_DIV - 1);
	localparam logic [MICRO_W-1:0] MICRO_LAST = MICRO_W'(MICRO_TICKS - 1);
	localparam logic [PULSE_W-1:0] PULSE_MIN  = PULSE_W'(`HALL_PULSE_MIN_CYC);

	if (OSC_DIV < 2) begin : g_bad_div
		$error("hall_sample_mode_control: oscillator divider must be at least 2");
	end
	if (MICRO_TICKS <= `HALL_PULSED_TICKS) begin : g_bad_micro
		$error("hall_sample_mode_control: low-power period shorter than a conversion");
	end
	if (`HALL_AWAKE_TICKS >= (1 << SEQ_W)) begin : g_bad_seq
		$error("hall_sample_mode_control: phase counter too narrow");
	end

	// ticks in each phase of the sequence, minus one
	function automatic logic [SEQ_W-1:0] phase_last(input hall_pkg::seq_state_e st);
		case (st)
			hall_pkg::ST_DELAY:  phase_last = SEQ_W'(`HALL_DELAY_TICKS - 1);
			hall_pkg::ST_AWAKE:  phase_last = SEQ_W'(`HALL_AWAKE_TICKS - 1);
			hall_pkg::ST_UPDATE: phase_last = SEQ_W'(`HALL_UPDATE_TICKS - 1);
			hall_pkg::ST_GAP:    phase_last = SEQ_W'(`HALL_GAP_TICKS - 1);
			default:             phase_last = '0;
		endcase
	endfunction

	// pad synchroniser: bit 1 is the driven flag, bit 0 the level
	logic [1:0] pin_meta_q;
	logic [1:0] pin_sync_q;
	logic       pin_prev_q;

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {mode_pin_driven_in, mode_control_pin_in};
			pin_sync_q <= pin_meta_q;
		end
	end

	// internal pull-down
	// a floating pin counts as low, so the part wakes in low-power mode
	wire logic pin_high;
	wire logic pin_rise;

	assign pin_high = pin_sync_q[1] & pin_sync_q[0];
	assign pin_rise = pin_high & ~pin_prev_q;

	// sequencer state
	hall_pkg::seq_state_e state_q;
	hall_pkg::seq_state_e state_d;
	hall_pkg::conv_mode_e mode_q;
	hall_pkg::conv_mode_e mode_d;
	logic [SEQ_W-1:0]     seq_cnt_q;
	logic [SEQ_W-1:0]     seq_cnt_d;
	logic [DIV_W-1:0]     div_q;
	logic [MICRO_W-1:0]   micro_cnt_q;
	logic [PULSE_W-1:0]   high_cnt_q;
	logic                 armed_q;
	logic                 stay_high_q;
	logic [`HALL_CODE_W-1:0] output_code_q;
	hall_pkg::status_s    status_q;

	wire logic                    tick;
	wire logic                    in_sleep;
	wire logic                    phase_end;
	wire logic                    pulse_ok;
	wire logic                    start_pulse;
	wire logic                    micro_due;
	wire logic                    any_start;
	wire logic                    load_output;
	wire logic                    turbo_next;
	wire logic [`HALL_CODE_W-1:0] adc_code;
	hall_pkg::status_s            status_d;

	// internal oscillator
	// every phase is counted in these ticks, one per 10 us
	assign tick      = (div_q == DIV_LAST);
	assign in_sleep  = (state_q == hall_pkg::ST_SLEEP);
	assign phase_end = tick & (seq_cnt_q == phase_last(state_q));

	// start pulse width
	// a rise only counts once the pin has stayed high this long, so
	// short glitches on the line never start a conversion
	assign pulse_ok    = armed_q & (high_cnt_q == PULSE_MIN);
	// one pulse, one conversion
	// edges seen while busy stay armed only while the pin stays high, then are served from sleep
	assign start_pulse = in_sleep & pulse_ok;
	// low-power schedule
	// an unbroken low level samples once per period on its own
	assign micro_due   = in_sleep & tick & ~pin_high & (micro_cnt_q == MICRO_LAST);
	assign any_start   = start_pulse | micro_due;
	// back to back in turbo
	// a level high since the last start keeps the chain running
	assign turbo_next  = stay_high_q & pin_high;
	assign load_output = (state_q == hall_pkg::ST_AWAKE) & phase_end;

	always_comb begin
		state_d   = state_q;
		mode_d    = mode_q;
		seq_cnt_d = tick ? seq_cnt_q + SEQ_W'(1) : seq_cnt_q;
		case (state_q)
			hall_pkg::ST_SLEEP: begin
				seq_cnt_d = '0;
				if (start_pulse) begin
					state_d = hall_pkg::ST_DELAY;
					mode_d  = hall_pkg::MODE_PULSED;
				end else if (micro_due) begin
					state_d = hall_pkg::ST_DELAY;
					mode_d  = hall_pkg::MODE_MICRO;
				end
			end
			hall_pkg::ST_DELAY: begin
				if (phase_end) begin
					state_d   = hall_pkg::ST_AWAKE;
					seq_cnt_d = '0;
				end
			end
			hall_pkg::ST_AWAKE: begin
				if (phase_end) begin
					state_d   = hall_pkg::ST_UPDATE;
					seq_cnt_d = '0;
				end
			end
			// fourteen tick sequence
			// delay, awake and update add to the pulsed conversion time
			hall_pkg::ST_UPDATE: begin
				if (phase_end) begin
					seq_cnt_d = '0;
					if (turbo_next) begin
						state_d = hall_pkg::ST_GAP;
						mode_d  = hall_pkg::MODE_TURBO;
					end else begin
						state_d = hall_pkg::ST_SLEEP;
					end
				end
			end
			// two idle ticks stretch a turbo conversion to sixteen
			hall_pkg::ST_GAP: begin
				if (phase_end) begin
					state_d   = hall_pkg::ST_DELAY;
					seq_cnt_d = '0;
				end
			end
			default: begin
				state_d   = hall_pkg::ST_SLEEP;
				seq_cnt_d = '0;
			end
		endcase
	end

	always_comb begin
		status_d.busy   = (state_d != hall_pkg::ST_SLEEP);
		status_d.awake  = (state_d == hall_pkg::ST_AWAKE);
		status_d.update = (state_d == hall_pkg::ST_UPDATE);
		status_d.mode   = mode_d;
	end

	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_q   <= hall_pkg::ST_SLEEP;
			mode_q    <= hall_pkg::MODE_MICRO;
			seq_cnt_q <= '0;
			status_q  <= '0;
		end else begin
			state_q   <= state_d;
			mode_q    <= mode_d;
			seq_cnt_q <= seq_cnt_d;
			status_q  <= status_d;
		end
	end

	// oscillator phase restarts on a pulse start so the delay is a whole tick
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div_q <= '0;
		end else if (start_pulse || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + DIV_W'(1);
		end
	end

	// period counter is cleared by any high level, so only an unbroken low counts
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			micro_cnt_q <= '0;
		end else if (pin_high || any_start) begin
			micro_cnt_q <= '0;
		end else if (tick && micro_cnt_q != MICRO_LAST) begin
			micro_cnt_q <= micro_cnt_q + MICRO_W'(1);
		end
	end

	// high time of the current pulse, saturating at the width limit
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			high_cnt_q <= '0;
		end else if (!pin_high) begin
			high_cnt_q <= '0;
		end else if (high_cnt_q != PULSE_MIN) begin
			high_cnt_q <= high_cnt_q + PULSE_W'(1);
		end
	end

	// armed by a rise, spent by the start it causes, lost on a short glitch
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_prev_q <= 1'h0;
			armed_q    <= 1'h0;
		end else begin
			pin_prev_q <= pin_high;
			if (pin_rise) begin
				armed_q <= 1'h1;
			end else if (!pin_high || start_pulse) begin
				armed_q <= 1'h0;
			end
		end
	end

	// any low during a conversion ends the turbo chain at its update
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stay_high_q <= 1'h0;
		end else if (start_pulse) begin
			stay_high_q <= 1'h1;
		end else if (!pin_high) begin
			stay_high_q <= 1'h0;
		end
	end

	field_quantizer #(
		.FIELD_W (FIELD_W),
		.FRAC_W  (FRAC_W)
	) u_quantizer (
		.clock_in (clock_in),
		.rst_b_in (rst_b_in),
		.field_in (field_sample_in),
		.code_out (adc_code)
	);

	// output update
	// the result taken at the end of the awake phase drives the output
	// stage for the whole update tick and beyond
	// hold between updates
	// ratiometric code
	// the code is the output level in steps of supply over 256
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			output_code_q <= `HALL_CODE_RESET;
		end else if (load_output) begin
			output_code_q <= adc_code;
		end
	end

	assign output_code_out = output_code_q;
	assign status_out      = status_q;

endmodule

`default_nettype wire

//--- hall_sample_mode_control_tb.sv
// self-checking bench for the hall sample and mode control block
// assumes host_pin_model and the bound checker are compiled with it
`timescale 1ns/1ns
`default_nettype none
module hall_sample_mode_control_tb;
	typedef struct {
		logic [15:0] f;
		logic [7:0]  c;
	} row_s;
	// short tick, yet a 400 clock pulse still ends inside one conversion
	localparam int DIV = 40;
	logic               clock_in = 1'b0;
	logic               rst_b_in = 1'b0;
	logic               req = 1'b0;
	logic [15:0]        width = 16'h0190;
	logic [1:0]         level = 2'h1;
	logic signed [15:0] field = 16'h0000;
	logic               pin;
	logic               driven;
	logic               seen;
	logic [7:0]         code;
	hall_pkg::status_s  st;
	int                 bad_count = 0;
	int                 n_compared = 0;
	int                 cyc = 0;
	row_s               rows [11] = '{
		'{16'h0000, 8'h7f}, '{16'h0001, 8'h80}, '{16'h0100, 8'h80}, '{16'h0101, 8'h81},
		'{16'hffff, 8'h7f}, '{16'hff01, 8'h7f}, '{16'hff00, 8'h7e}, '{16'h0201, 8'h82},
		'{16'hfe00, 8'h7d}, '{16'h7fff, 8'hff}, '{16'h8000, 8'h00}};
	host_pin_model host_pin_model_i (.clock_in(clock_in), .req_in(req), .width_in(width),
		.level_in(level), .pin_out(pin), .driven_out(driven));
	hall_sample_mode_control #(.OSC_DIV(DIV), .MICRO_TICKS(20)) hall_sample_mode_control_i (
		.clock_in(clock_in), .rst_b_in(rst_b_in), .mode_control_pin_in(pin),
		.mode_pin_driven_in(driven), .field_sample_in(field), .output_code_out(code),
		.status_out(st));
	always #50 clock_in = ~clock_in;
	task automatic print_verdict;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		n_compared++;
		if (got !== want) begin
			bad_count++;
			$display("ERROR at %0t: saw %h expected %h", $time, got, want);
		end
	endtask
	task automatic pulse(input logic [15:0] w);
		@(posedge clock_in);
		width <= w;
		req <= 1'b1;
		@(posedge clock_in);
		req <= 1'b0;
	endtask
	// status bits: 4 busy, 3 awake, 2 update
	task automatic wait_for(input int b, input logic v, input int lim);
		int n;
		n = 0;
		@(negedge clock_in);
		while (st[b] !== v && n < lim) begin
			@(negedge clock_in);
			n++;
		end
		if (n >= lim) begin
			bad_count++;
			$display("ERROR at %0t: status wait ran out", $time);
		end
	endtask
	initial begin
		repeat (5) @(posedge clock_in);
		rst_b_in <= 1'b1;
		@(negedge clock_in);
		check(code, 8'h80);
		check({3'h0, st}, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			@(posedge clock_in);
			field <= rows[i].f;
			pulse(16'h0190);
			wait_for(2, 1'b1, 1500);
			check(code, rows[i].c);
			check({6'h0, st.mode}, 8'h03);
			wait_for(4, 1'b0, 200);
		end
		$display("test rows done");
		@(posedge clock_in);
		field <= 16'h4000;
		repeat (100) @(posedge clock_in);
		check(code, 8'h00);
		pulse(16'h0096);
		seen = 1'b0;
		repeat (400) begin
			@(negedge clock_in);
			seen = seen | st.busy;
		end
		check({7'h0, seen}, 8'h00);
		$display("test hold and short pulse done");
		@(posedge clock_in);
		field <= 16'h0201;
		level <= 2'h2;
		wait_for(2, 1'b1, 1500);
		check(code, 8'h82);
		@(posedge clock_in);
		field <= 16'hfe00;
		wait_for(2, 1'b0, 100);
		wait_for(2, 1'b1, 800);
		check({6'h0, st.mode}, 8'h01);
		check(code, 8'h7d);
		@(posedge clock_in);
		level <= 2'h1;
		wait_for(4, 1'b0, 1500);
		$display("test turbo done");
		@(posedge clock_in);
		level <= 2'h0;
		field <= 16'hff00;
		wait_for(4, 1'b1, 1200);
		check({6'h0, st.mode}, 8'h00);
		wait_for(2, 1'b1, 800);
		check(code, 8'h7e);
		wait_for(4, 1'b0, 200);
		$display("test idle sampling done");
		@(posedge clock_in);
		level <= 2'h1;
		pulse(16'h0190);
		wait_for(3, 1'b1, 600);
		@(posedge clock_in);
		rst_b_in <= 1'b0;
		@(negedge clock_in);
		check(code, 8'h80);
		check({3'h0, st}, 8'h00);
		@(posedge clock_in);
		rst_b_in <= 1'b1;
		repeat (2) @(posedge clock_in);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule
`default_nettype wire

//--- hall_seq_sva.sv
// assertions on sequencing and output hold of the hall readout
// assumes it is bound into hall_sample_mode_control, one clock domain
`timescale 1ns/1ns
`default_nettype none
module hall_seq_sva #(
	parameter int OSC_DIV     = 40,
	parameter int MICRO_TICKS = 20
) (
	input wire logic              clock_in,
	input wire logic              rst_b_in,
	input wire logic              mode_control_pin_in,
	input wire logic              mode_pin_driven_in,
	input wire logic [7:0]        output_code_out,
	input wire hall_pkg::status_s status_out
);
	logic [2:0]  ph;
	logic [2:0]  ph_q;
	logic [15:0] cnt_q;
	logic [15:0] seq_q;
	logic [15:0] upd_q;
	logic [15:0] run_q;
	logic [15:0] last_q;
	logic [15:0] idle_q;
	logic        hi;
	assign ph = {status_out.busy, status_out.awake, status_out.update};
	assign hi = mode_control_pin_in & mode_pin_driven_in;
	// clocks spent per phase, since a start from sleep, since update, high and idle
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ph_q   <= 3'h0;
			cnt_q  <= 16'h0000;
			seq_q  <= 16'h0000;
			upd_q  <= 16'h0000;
			run_q  <= 16'h0000;
			last_q <= 16'h0000;
			idle_q <= 16'h0000;
		end else begin
			ph_q   <= ph;
			cnt_q  <= (ph != ph_q) ? 16'h0001 : cnt_q + 16'h0001;
			seq_q  <= (ph == 3'h4 && ph_q == 3'h0) ? 16'h0001 : seq_q + 16'h0001;
			upd_q  <= (ph[0] && !ph_q[0]) ? 16'h0001 : upd_q + 16'h0001;
			run_q  <= hi ? run_q + 16'h0001 : 16'h0000;
			last_q <= (!hi && run_q != 16'h0000) ? run_q : last_q;
			idle_q <= (hi || (ph[2] && !ph_q[2])) ? 16'h0000 : idle_q + 16'h0001;
		end
	end
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	sequence s_pstart; $rose(status_out.busy) && status_out.mode == hall_pkg::MODE_PULSED; endsequence
	sequence s_mstart; $rose(status_out.busy) && status_out.mode == hall_pkg::MODE_MICRO; endsequence
	property p_hold; !$rose(status_out.update) |-> $stable(output_code_out); endproperty
	a_hold: assert property (p_hold) else $error("code moved outside update");
	// the delay after a turbo gap shows as gap plus delay
	property p_delay; $rose(status_out.awake) |-> cnt_q == OSC_DIV
		|| (status_out.mode == hall_pkg::MODE_TURBO && cnt_q == 3 * OSC_DIV); endproperty
	a_delay: assert property (p_delay) else $error("trigger delay length wrong");
	property p_awake; $rose(status_out.update) |-> cnt_q == 12 * OSC_DIV; endproperty
	a_awake: assert property (p_awake) else $error("awake length wrong");
	property p_update; $fell(status_out.update) |-> cnt_q == OSC_DIV; endproperty
	a_update: assert property (p_update) else $error("update length wrong");
	property p_pulsed; $fell(status_out.busy) && status_out.mode != hall_pkg::MODE_TURBO
		|-> seq_q == 14 * OSC_DIV; endproperty
	a_pulsed: assert property (p_pulsed) else $error("conversion length wrong");
	property p_turbo; $rose(status_out.update) && status_out.mode == hall_pkg::MODE_TURBO
		|-> upd_q == 16 * OSC_DIV; endproperty
	a_turbo: assert property (p_turbo) else $error("turbo period wrong");
	property p_pulse_min; s_pstart |-> run_q >= 200 || last_q >= 200; endproperty
	a_pulse_min: assert property (p_pulse_min) else $error("short pulse started");
	property p_micro; s_mstart |-> idle_q >= (MICRO_TICKS - 1) * OSC_DIV
		&& idle_q <= (MICRO_TICKS + 3) * OSC_DIV; endproperty
	a_micro: assert property (p_micro) else $error("idle sample off time");
endmodule
bind hall_sample_mode_control hall_seq_sva #(.OSC_DIV(OSC_DIV), .MICRO_TICKS(MICRO_TICKS))
	hall_seq_sva_i (.clock_in(clock_in), .rst_b_in(rst_b_in),
	.mode_control_pin_in(mode_control_pin_in), .mode_pin_driven_in(mode_pin_driven_in),
	.output_code_out(output_code_out), .status_out(status_out));
`default_nettype wire

//--- host_pin_model.sv
// host side of the mode control pin: held levels, a released pin, single pulses
// assumes requests and levels change just after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
module host_pin_model (
	input  wire logic        clock_in,
	input  wire logic        req_in,
	input  wire logic [15:0] width_in,
	input  wire logic [1:0]  level_in,
	output logic             pin_out,
	output logic             driven_out
);
	logic [15:0] left_q = 16'h0000;
	logic        wobble_q = 1'b0;
	always @(posedge clock_in) begin
		left_q <= req_in ? width_in : left_q - 16'(left_q != 16'h0000);
		wobble_q <= !wobble_q;
	end
	assign pin_out = (left_q != 16'h0000) ? 1'b1 : (level_in == 2'h0) ? wobble_q : level_in[1];
	assign driven_out = (left_q != 16'h0000) || (level_in != 2'h0);
endmodule
`default_nettype wire
